/* headphone_amp_mode_volume_ctrl_bench.sv */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end
module headphone_amp_mode_volume_ctrl_bench;
  logic               clk;
  logic               reset = 1'b1;
  logic               scl_clk;
  logic               sda_pull;
  logic               sda_in;
  logic               sda_out;
  logic               sda_oe;
  hp_ctrl_pkg::ctrl_t ctrl;
  int                 n_errors;
  int                 check_count;
  logic [7:0]         mode_w; // Shadow of the mode word
  logic [7:0]         gain_w; // Shadow of the gain word

  // Pull-up: the line is low only while someone pulls it
  assign sda_in = ~(sda_pull | (sda_oe & ~sda_out));

  hp_amp_ctrl dut (.clk(clk), .reset(reset), .scl_clk(scl_clk), .sda_in(sda_in),
                   .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl));
  hp_bus_master bus (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_in(sda_in));

  // Main clock, 10 ns
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Expected controls from the written words
  function automatic hp_ctrl_pkg::ctrl_t exp_ctrl();
    hp_ctrl_pkg::ctrl_t c;
    logic               run;
    logic               amp;
  begin
    run = ~gain_w[6];
    amp = run & ~mode_w[4];
    c.amp_left_en  = amp & ~mode_w[6];
    c.amp_right_en = amp & ~mode_w[1];
    c.pump_en      = run;
    c.bias_en      = amp & mode_w[5];
    c.mute_left    = run & mode_w[2];
    c.mute_right   = run & mode_w[0];
    c.mono_sum     = amp & mode_w[1] & ~mode_w[6];
    c.gain_code    = gain_w[5:0];
    c.gain_floor   = (gain_w[5:0] == 6'h00);
    c.gain_fine    = (gain_w[5:0] >= 6'h1f);
    return c;
  end
  endfunction : exp_ctrl

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Reset with bus pulses inside it, then check the controls decoded from cleared words
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    bus.idle_pulses();
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    mode_w = 8'h00;
    gain_w = 8'h00;
    `CHK("reset ctrl", exp_ctrl(), ctrl)
    `CHK("floor flag", 1'b1, ctrl.gain_floor)
  endtask : t_reset

  // Acked write, then the decoded controls
  task automatic send(input logic [7:0] w);
    logic aa;
    logic ad;
  begin
    @(posedge clk);
    #1.3;
    bus.write(hp_ctrl_pkg::DEV_ADDR, 1'b0, w, 8, aa, ad);
    `CHK("addr ack", 1'b1, aa)
    `CHK("data ack", 1'b1, ad)
    if (w[7]) gain_w = w;
    else mode_w = w;
    repeat (8) @(posedge clk);
    `CHK("ctrl", exp_ctrl(), ctrl)
  end
  endtask : send

  // Channel offs, mono, mutes, bias, pump alone
  task automatic t_modes();
    logic [7:0] tbl [8] = '{8'h00, 8'h02, 8'h40, 8'h42, 8'h05, 8'h20, 8'h73, 8'h24};
    foreach (tbl[i]) send(tbl[i]);
  endtask : t_modes

  // Gain codes around the table anchors
  task automatic t_gain();
    logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h1e, 6'h1f, 6'h20, 6'h3f};
    foreach (codes[i]) send({2'b10, codes[i]});
  endtask : t_gain

  // Global power off overrides mode settings written during it
  task automatic t_shutdown();
    send(8'h27);
    send(8'hdf);
    send(8'h52);
    send(8'h9f);
  endtask : t_shutdown

  // Wrong address, read bit and aborted byte leave controls alone
  task automatic t_refuse();
    logic aa;
    logic ad;
  begin
    @(posedge clk);
    #1.3;
    bus.write(hp_ctrl_pkg::DEV_ADDR ^ 7'h01, 1'b0, 8'h42, 8, aa, ad);
    `CHK("foreign ack", 1'b0, aa | ad)
    bus.write(hp_ctrl_pkg::DEV_ADDR, 1'b1, 8'h42, 8, aa, ad);
    `CHK("read ack", 1'b0, aa | ad)
    bus.write(hp_ctrl_pkg::DEV_ADDR, 1'b0, 8'h42, 4, aa, ad);
    repeat (8) @(posedge clk);
    `CHK("abort ctrl", exp_ctrl(), ctrl)
  end
  endtask : t_refuse

  // Main sequence, ending with a reset in mid-run
  initial
  begin
    n_errors    = 0;
    check_count = 0;
    t_reset();
    t_modes();
    t_gain();
    t_shutdown();
    t_refuse();
    t_reset();
    end_sim();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    #300000;
    n_errors++;
    end_sim();
  end
endmodule : headphone_amp_mode_volume_ctrl_bench

/* hp_amp_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - Mode bits 6/1 switch left/right off
// - Right off only: left output sums both
// - Left off only: right carries right alone
// - Both off: amplifiers off, pump stays
// - Gain word bit 6 powers all off
// - Global power off overrides every mode-word setting; gain code still passes
// - Mode bits 2/0 mute left/right
// - Mode bit 5 high enables bias
// - Codes 1f..3f give -12..+4 dB
// - Write-only slave: address, ack, byte, ack
// - Data bit 7 selects target word
// - Pump-alone bit kills amplifiers and bias
// - Code 0 is -96 dB floor
module hp_amp_ctrl
(
  // Main clock and reset
  input  wire logic           clk,
  input  wire logic           reset,
  // Two-wire bus pins; SCL clocks the link logic
  input  wire logic           scl_clk,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  // Decoded controls
  output hp_ctrl_pkg::ctrl_t  ctrl
);

  // Main-domain state except rst_link_q
  typedef struct packed {
    logic [1:0]          tsync;     // Toggle synchroniser
    logic                tseen;     // Last toggle acted on
    logic [7:0]          dhold;     // Word sampled after settle
    logic                dvalid;
    logic [7:0]          amp_mode_word;
    logic [7:0]          gain_and_power_word;
    hp_ctrl_pkg::ctrl_t  out;
  } st_t;

  st_t q, d;
  hp_ctrl_pkg::rx_word_t rxw;
  logic [1:0] rst_link_q;           // Reset carried to link side

  hp_link_rx u_rx
  (
    .scl_clk    (scl_clk),
    .link_reset (rst_link_q[1]),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .word       (rxw)
  );

  // Reset level passed to link domain; asserted on the next main clock, cleared
  // after two main clocks so the link never sees a partial release
  always_ff @(posedge clk)
  begin
    if (reset)
      rst_link_q <= 2'b11;
    else
      rst_link_q <= {rst_link_q[0], 1'b0};
  end

  // Next state: toggle crossing, register writes, decode
  always_comb
  begin
    logic lo, ro, mute_ok;
    d      = q;
    lo     = 1'b0;
    ro     = 1'b0;
    mute_ok = 1'b0;
    d.tsync = {q.tsync[0], rxw.tog};
    d.dvalid = 1'b0;
    // Data is stable for a whole byte after the toggle, so it is safe
    // to take once the synchronised toggle shows the change
    if (q.tsync[1] != q.tseen)
    begin
      d.tseen  = q.tsync[1];
      d.dhold  = rxw.data;
      d.dvalid = 1'b1;
    end
    if (q.dvalid)
    begin
      if (q.dhold[hp_ctrl_pkg::SEL_BIT])
        d.gain_and_power_word = q.dhold;
      else
        d.amp_mode_word = q.dhold;
    end
    // Decode from the stored words
    lo = q.amp_mode_word[hp_ctrl_pkg::LEFT_OFF];
    ro = q.amp_mode_word[hp_ctrl_pkg::RIGHT_OFF];
    d.out = '0;
    if (q.gain_and_power_word[hp_ctrl_pkg::POWER_OFF])
    begin
      // Enables and routing off regardless of mode bits; gain code set below
      d.out = '0;
    end
    else if (q.amp_mode_word[hp_ctrl_pkg::PUMP_ALONE])
    begin
      d.out.pump_en = 1'b1;
    end
    else
    begin
      d.out.pump_en      = 1'b1;
      d.out.amp_left_en  = ~lo;
      d.out.amp_right_en = ~ro;
      d.out.mono_sum     = ro & ~lo;
      d.out.bias_en      = q.amp_mode_word[hp_ctrl_pkg::BIAS_BIT];
    end
    mute_ok = ~q.gain_and_power_word[hp_ctrl_pkg::POWER_OFF];
    d.out.mute_left  = mute_ok & q.amp_mode_word[hp_ctrl_pkg::MUTE_L_BIT];
    d.out.mute_right = mute_ok & q.amp_mode_word[hp_ctrl_pkg::MUTE_R_BIT];
    d.out.gain_code  = q.gain_and_power_word[hp_ctrl_pkg::GAIN_MSB:0];
    d.out.gain_floor = (d.out.gain_code == hp_ctrl_pkg::GAIN_FLOOR);
    d.out.gain_fine  = (d.out.gain_code >= hp_ctrl_pkg::GAIN_FINE_BASE);
  end

  // State register
  // Words clear on reset; the link is held in reset two clocks longer
  // so no stale byte can arrive while the words are still clearing
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q                     <= '0;
      q.amp_mode_word       <= hp_ctrl_pkg::MODE_RST;
      q.gain_and_power_word <= hp_ctrl_pkg::GAIN_RST;
      q.out.gain_floor      <= 1'b1;
    end
    else
      q <= d;
  end

  assign ctrl = q.out;

  // Shutdown clears all enables one cycle after the word holds it
  shutdown_all_a: assert property (@(posedge clk) disable iff (reset)
    $past(q.gain_and_power_word[hp_ctrl_pkg::POWER_OFF]) |->
      !(ctrl.pump_en || ctrl.amp_left_en || ctrl.amp_right_en || ctrl.bias_en))
    else $error("enable active under global shutdown");

  sequence pump_alone_s;
    !q.gain_and_power_word[hp_ctrl_pkg::POWER_OFF] && q.amp_mode_word[hp_ctrl_pkg::PUMP_ALONE];
  endsequence
  pump_alone_a: assert property (@(posedge clk) disable iff (reset)
    pump_alone_s ##1 1'b1 |-> ctrl.pump_en && !ctrl.amp_left_en && !ctrl.bias_en)
    else $error("pump alone mode decoded wrong");

  mono_route_a: assert property (@(posedge clk) disable iff (reset)
    ctrl.mono_sum |-> ctrl.amp_left_en && !ctrl.amp_right_en)
    else $error("mono summing without left only");

  both_off_a: assert property (@(posedge clk) disable iff (reset)
    !ctrl.amp_left_en && !ctrl.amp_right_en && $past(q.amp_mode_word[1] && q.amp_mode_word[6]
      && !q.gain_and_power_word[6]) |-> ctrl.pump_en)
    else $error("pump dropped with both channels off");

  left_only_off_a: assert property (@(posedge clk) disable iff (reset)
    $past(q.amp_mode_word[6:4] == 3'b100 && !q.amp_mode_word[1]
      && !q.gain_and_power_word[6]) |-> !ctrl.amp_left_en && ctrl.amp_right_en
      && !ctrl.mono_sum)
    else $error("left off routing wrong");

  bias_follow_a: assert property (@(posedge clk) disable iff (reset)
    $past(q.amp_mode_word[5:4] == 2'b10 && !q.gain_and_power_word[6]) |-> ctrl.bias_en)
    else $error("bias not enabled");

  word_select_a: assert property (@(posedge clk) disable iff (reset)
    q.dvalid && q.dhold[7] |=> q.gain_and_power_word == $past(q.dhold))
    else $error("volume word not written");

  floor_code_a: assert property (@(posedge clk) disable iff (reset)
    ctrl.gain_floor |-> ctrl.gain_code == 6'h00 && !ctrl.gain_fine)
    else $error("floor code flag wrong");

  // Right off alone routes the mono sum to the left output
  right_only_off_a: assert property (@(posedge clk) disable iff (reset)
    $past(q.amp_mode_word[6:4] == 3'b000 && q.amp_mode_word[1]
      && !q.gain_and_power_word[6]) |-> ctrl.amp_left_en && !ctrl.amp_right_en
      && ctrl.mono_sum)
    else $error("right off routing wrong");

  // Mutes follow their bits while the device runs
  sequence run_mute_l_s;
    !q.gain_and_power_word[hp_ctrl_pkg::POWER_OFF] && q.amp_mode_word[hp_ctrl_pkg::MUTE_L_BIT];
  endsequence
  sequence run_mute_r_s;
    !q.gain_and_power_word[hp_ctrl_pkg::POWER_OFF] && q.amp_mode_word[hp_ctrl_pkg::MUTE_R_BIT];
  endsequence
  mute_left_a: assert property (@(posedge clk) disable iff (reset)
    run_mute_l_s ##1 1'b1 |-> ctrl.mute_left)
    else $error("left mute not applied");
  mute_right_a: assert property (@(posedge clk) disable iff (reset)
    run_mute_r_s ##1 1'b1 |-> ctrl.mute_right)
    else $error("right mute not applied");

  // Upper gain codes flagged as the fine half-step range
  gain_fine_a: assert property (@(posedge clk) disable iff (reset)
    $past(q.gain_and_power_word[5:0] >= 6'h1f) |-> ctrl.gain_fine)
    else $error("fine gain flag missing");

  // Global power off also drops mono routing
  shutdown_route_a: assert property (@(posedge clk) disable iff (reset)
    $past(q.gain_and_power_word[6]) |-> !ctrl.mono_sum)
    else $error("routing active under global shutdown");

  // Both words read as cleared right after reset
  reset_clear_a: assert property (@(posedge clk)
    $past(reset) |-> q.amp_mode_word == 8'h00 && q.gain_and_power_word == 8'h00)
    else $error("control words not cleared by reset");

endmodule : hp_amp_ctrl

/* hp_bus_master.sv */
`timescale 1ns/1ps
// Bus master model; its clock stands high between frames
module hp_bus_master
(
  // Bus pins
  output logic      scl_clk,
  output logic      sda_pull,
  input  wire logic sda_in
);
  // Quarter of the 6 ns bus period
  localparam real QTR = 1.5;

  // Idle bus: clock high, data released
  initial
  begin
    scl_clk  = 1'b1;
    sda_pull = 1'b0;
  end

  // One bit slot; data only moves while the clock is low
  task automatic slot(input logic b, output logic seen);
  begin
    scl_clk  = 1'b0;
    #(QTR);
    sda_pull = ~b;
    #(QTR);
    scl_clk  = 1'b1;
    seen     = sda_in;
    #(2 * QTR);
  end
  endtask : slot

  // Clock pulses with data released, to settle the slave in reset
  task automatic idle_pulses();
    logic s;
  begin
    repeat (2) slot(1'b1, s);
  end
  endtask : idle_pulses

  // Full write frame; fewer than 8 data bits aborts with a stop
  task automatic write(input logic [6:0] addr, input logic rw, input logic [7:0] data,
                       input int nbits, output logic ack_a, output logic ack_d);
    logic s;
  begin
    sda_pull = 1'b1;
    #(2 * QTR);
    for (int i = 6; i >= 0; i--) slot(addr[i], s);
    slot(rw, s);
    slot(1'b1, s);
    ack_a = ~s;
    for (int i = 7; i >= 8 - nbits; i--) slot(data[i], s);
    ack_d = 1'b0;
    if (nbits == 8)
    begin
      slot(1'b1, s);
      ack_d = ~s;
    end
    // Stop: data rises while the clock is high
    scl_clk  = 1'b0;
    #(QTR);
    sda_pull = 1'b1;
    #(QTR);
    scl_clk  = 1'b1;
    #(QTR);
    sda_pull = 1'b0;
    #(2 * QTR);
  end
  endtask : write
endmodule : hp_bus_master

/* hp_ctrl_pkg.sv */
package hp_ctrl_pkg;

  // Bus address of this device (7 bits, arbitrary neutral value)
  localparam logic [6:0] DEV_ADDR    = 7'h60;

  // Register select bit and mode word field positions
  localparam int SEL_BIT     = 7;
  localparam int LEFT_OFF    = 6;
  localparam int BIAS_BIT    = 5;
  localparam int PUMP_ALONE  = 4;
  localparam int MUTE_L_BIT  = 2;
  localparam int RIGHT_OFF   = 1;
  localparam int MUTE_R_BIT  = 0;

  // Gain word field positions
  localparam int POWER_OFF   = 6;
  localparam int GAIN_MSB    = 5;

  // Values after reset
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] GAIN_RST  = 8'h00;

  // Gain table anchors: code 6'h1f is -12 dB, 6'h3f is +4 dB
  localparam logic [5:0] GAIN_FINE_BASE = 6'h1f;
  localparam logic [5:0] GAIN_FLOOR     = 6'h00;

  // Received byte handed from the link domain
  typedef struct packed {
    logic [7:0] data;
    logic       tog;
  } rx_word_t;

  // Decoded controls
  typedef struct packed {
    logic       amp_left_en;
    logic       amp_right_en;
    logic       pump_en;
    logic       bias_en;
    logic       mute_left;
    logic       mute_right;
    logic       mono_sum;
    logic       gain_floor;
    logic       gain_fine;
    logic [5:0] gain_code;
  } ctrl_t;

endpackage : hp_ctrl_pkg

/* hp_link_rx.sv */
`timescale 1ns/1ps
// Serial two-wire write slave, clocked by the bus clock itself
module hp_link_rx
(
  // Link clock and reset level from the main domain
  input  wire logic                  scl_clk,
  input  wire logic                  link_reset,
  // Data pin
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  // Word toward the main domain
  output hp_ctrl_pkg::rx_word_t      word
);

  // Link state
  typedef enum logic [2:0]
  {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_AACK = 3'b010,
    L_DATA = 3'b011,
    L_DACK = 3'b100
  } lstate_t;

  typedef struct packed {
    lstate_t    st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic       ack;
    hp_ctrl_pkg::rx_word_t w;
  } lnk_t;

  lnk_t q, d;
  logic start_tog, stop_tog;   // Set by SDA edges while SCL high
  logic start_seen_q, stop_seen_q;

  // Start and stop are SDA edges; SCL is the only clock here, so edges
  // of SDA while SCL is high are caught as toggles on SDA itself
  always_ff @(negedge sda_in or posedge link_reset)
  begin
    if (link_reset)
      start_tog <= 1'b0;
    else if (scl_clk)
      start_tog <= ~start_tog;
  end

  always_ff @(posedge sda_in or posedge link_reset)
  begin
    if (link_reset)
      stop_tog <= 1'b0;
    else if (scl_clk)
      stop_tog <= ~stop_tog;
  end

  // Next state on each rising edge of SCL
  always_comb
  begin
    d = q;
    if (start_tog != start_seen_q)
    begin
      // Fresh start: first address bit sampled now
      d.st  = L_ADDR;
      d.cnt = 3'h1;
      d.sh  = {7'h00, sda_in};
    end
    else if (stop_tog != stop_seen_q)
      d.st = L_IDLE;
    else
    begin
      unique case (q.st)
        L_IDLE: d.st = L_IDLE;
        L_ADDR:
        begin
          d.sh  = {q.sh[6:0], sda_in};
          d.cnt = q.cnt + 3'h1;
          // Write-only: a read bit is not answered
          if (q.cnt == 3'h7)
            d.st = ({q.sh[6:0], sda_in} == {hp_ctrl_pkg::DEV_ADDR, 1'b0}) ? L_AACK : L_IDLE;
        end
        L_AACK:
        begin
          d.st  = L_DATA;
          d.cnt = 3'h0;
        end
        L_DATA:
        begin
          d.sh  = {q.sh[6:0], sda_in};
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == 3'h7)
            d.st = L_DACK;
        end
        L_DACK:
        begin
          // Byte handed over only after its acknowledge clock
          d.w.data = q.sh;
          d.w.tog  = ~q.w.tog;
          d.st     = L_IDLE;
        end
        default: d.st = L_IDLE;
      endcase
    end
  end

  // Reset taken at once: the bus clock stands still between frames, so a
  // reset waiting for an edge would leave a stale toggle after release
  always_ff @(posedge scl_clk or posedge link_reset)
  begin
    if (link_reset)
    begin
      q            <= '0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end
    else
    begin
      q            <= d;
      start_seen_q <= start_tog;
      stop_seen_q  <= stop_tog;
    end
  end

  // Acknowledge driven from the falling edge through the ack clock
  always_ff @(negedge scl_clk or posedge link_reset)
  begin
    if (link_reset)
      sda_oe <= 1'b0;
    else
      sda_oe <= (q.st == L_AACK) || (q.st == L_DACK);
  end

  assign sda_out = 1'b0;
  assign word    = q.w;

endmodule : hp_link_rx
